// ---- rtl/perf_event_control.sv ----
// per-strand performance control register with paired event counter
// How it works
// - nonprivileged access raises privileged-opcode trap, register unchanged
// - keep_high clear: load high flag from bit 31; bit 63 reads 0
// - keep_low clear: load low flag from bit 18; bit 62 reads 0
// - all other writable fields except the hypervisor bit update on every permitted write
// - high flag sets on upper half overflow or near-overflow increment
// - low flag sets on lower half overflow or near-overflow increment
// - bits 30:27 choose event group for upper half
// - bits 17:14 choose event group for lower half
// - bits 26:19 mask sub-events for upper half
// - bits 13:6 mask sub-events for lower half
// - trap field ANDed with flags requests overflow trap
// - groups 2,3 trap precisely when armed; else next instruction
// - hypervisor count bit writable only when hyperprivileged
// - user bit enables counting in user mode
// - supervisor bit enables counting in privileged mode
// - restrict bit denies user access to the counter
// - control writes never change counter values
// - group 0 counts core idle; group 1 reserved; others own strand
// - group 2 mask bits pick instruction classes, union counted
// - multi-match instruction increments once
// - atomics count as both load and store
// - upper half counts high select, lower half low select
// - overflow also sets soft interrupt bit 15; raises trap only if its trap field bit is set
`timescale 1ns/1ps
`default_nettype none
module perf_event_control #(
  parameter int cnt_w = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [1:0]        cur_priv,
  input  wire logic              ctl_wr,
  input  wire logic              ctl_rd,
  input  wire logic [7:0]        asr_addr,
  input  wire logic [63:0]       wr_data,
  input  wire logic              cnt_wr,
  input  wire logic              cnt_rd,
  input  wire logic [63:0]       cnt_wr_data,
  input  wire logic              core_idle,
  input  wire logic [7:0]        instr_class,
  input  wire logic              instr_valid,
  input  wire logic [7:0]        group_events,
  output logic [63:0]            rd_data,
  output logic [63:0]            counter_out,
  output logic                   priv_opcode_trap,
  output logic                   counter_access_trap,
  output logic                   overflow_trap_req,
  output logic                   precise_trap,
  output logic                   soft_interrupt_reg_ov_set
);
  // ----------------------------------------------------------------
  // privilege and access decode
  // ----------------------------------------------------------------
  perf_pkg::priv_e lvl;
  assign lvl = perf_pkg::priv_e'(cur_priv);
  wire logic is_user  = (lvl == perf_pkg::priv_user);
  wire logic is_hyp   = (lvl == perf_pkg::priv_hyp);
  wire logic hit      = (asr_addr == perf_pkg::perf_ctl_addr);
  wire logic acc      = hit && (ctl_wr || ctl_rd);
  wire logic bad_acc  = acc && is_user;
  wire logic do_wr    = hit && ctl_wr && !is_user;
  wire logic do_rd    = hit && ctl_rd && !is_user;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic       hi_ov_q, lo_ov_q;
  logic [3:0] hi_sel_q, lo_sel_q;
  logic [7:0] hi_mask_q, lo_mask_q;
  logic [1:0] trap_q;
  logic       hyp_q, user_q, sup_q, restrict_q;
  logic [cnt_w-1:0] hi_cnt_q, lo_cnt_q;

  // mode gating shared by both halves
  wire logic mode_ok = (is_user && user_q) ||
                       ((lvl == perf_pkg::priv_sup) && sup_q) ||
                       (is_hyp && hyp_q);

  // atomic class also flags load and store
  wire logic [7:0] cls_raw = instr_valid ? instr_class : 8'h00;
  wire logic [7:0] cls = cls_raw | (cls_raw[7] ? 8'h18 : 8'h00);

  // ----------------------------------------------------------------
  // counter halves
  // ----------------------------------------------------------------
  perf_half_if hi_if ();
  perf_half_if lo_if ();
  assign hi_if.sel          = hi_sel_q;
  assign hi_if.mask         = hi_mask_q;
  assign hi_if.count_en     = mode_ok;
  assign hi_if.core_idle    = core_idle;
  assign hi_if.instr_class  = cls;
  assign hi_if.group_events = group_events;
  assign hi_if.value        = hi_cnt_q;
  assign lo_if.sel          = lo_sel_q;
  assign lo_if.mask         = lo_mask_q;
  assign lo_if.count_en     = mode_ok;
  assign lo_if.core_idle    = core_idle;
  assign lo_if.instr_class  = cls;
  assign lo_if.group_events = group_events;
  assign lo_if.value        = lo_cnt_q;

  perf_half_sel u_hi (.h(hi_if));
  perf_half_sel u_lo (.h(lo_if));

  // ----------------------------------------------------------------
  // counter access
  // ----------------------------------------------------------------
  wire logic cnt_acc  = cnt_wr || cnt_rd;
  wire logic cnt_deny = cnt_acc && is_user && restrict_q;
  wire logic cnt_load = cnt_wr && !cnt_deny;

  // counters change only by events or a direct counter write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= '0;
      lo_cnt_q <= '0;
    end else if (cnt_load) begin
      hi_cnt_q <= cnt_wr_data[63:32];
      lo_cnt_q <= cnt_wr_data[31:0];
    end else begin
      hi_cnt_q <= hi_cnt_q + cnt_w'(hi_if.inc);
      lo_cnt_q <= lo_cnt_q + cnt_w'(lo_if.inc);
    end
  end

  // ----------------------------------------------------------------
  // overflow flags: set beats a software clear
  // ----------------------------------------------------------------
  wire logic hi_wr_ov = do_wr && !wr_data[perf_pkg::keep_hi_bit];
  wire logic lo_wr_ov = do_wr && !wr_data[perf_pkg::keep_lo_bit];
  wire logic hi_ov_d  = hi_if.ovf ? 1'b1 :
                        hi_wr_ov ? wr_data[perf_pkg::hi_ov_bit] : hi_ov_q;
  wire logic lo_ov_d  = lo_if.ovf ? 1'b1 :
                        lo_wr_ov ? wr_data[perf_pkg::lo_ov_bit] : lo_ov_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_ov_q <= 1'b0;
      lo_ov_q <= 1'b0;
    end else begin
      hi_ov_q <= hi_ov_d;
      lo_ov_q <= lo_ov_d;
    end
  end

  // ----------------------------------------------------------------
  // other fields update on every permitted write; hyp bit on hyperprivileged writes only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_sel_q   <= 4'h0;
      lo_sel_q   <= 4'h0;
      hi_mask_q  <= 8'h00;
      lo_mask_q  <= 8'h00;
      trap_q     <= 2'h0;
      hyp_q      <= 1'b0;
      user_q     <= 1'b0;
      sup_q      <= 1'b0;
      restrict_q <= 1'b0;
    end else if (do_wr) begin
      hi_sel_q   <= wr_data[perf_pkg::hi_sel_msb:perf_pkg::hi_sel_lsb];
      lo_sel_q   <= wr_data[perf_pkg::lo_sel_msb:perf_pkg::lo_sel_lsb];
      hi_mask_q  <= wr_data[perf_pkg::hi_mask_msb:perf_pkg::hi_mask_lsb];
      lo_mask_q  <= wr_data[perf_pkg::lo_mask_msb:perf_pkg::lo_mask_lsb];
      trap_q     <= wr_data[perf_pkg::trap_msb:perf_pkg::trap_lsb];
      user_q     <= wr_data[perf_pkg::user_bit];
      sup_q      <= wr_data[perf_pkg::sup_bit];
      restrict_q <= wr_data[perf_pkg::restrict_bit];
      if (is_hyp) begin
        hyp_q <= wr_data[perf_pkg::hyp_bit];
      end
    end
  end

  // ----------------------------------------------------------------
  // read image: keep bits and reserved bits read zero
  // ----------------------------------------------------------------
  wire logic [63:0] ctl_img = {2'b00, 30'h0,
                               hi_ov_q, hi_sel_q, hi_mask_q,
                               lo_ov_q, lo_sel_q, lo_mask_q,
                               trap_q, hyp_q, user_q, sup_q, restrict_q};

  // ----------------------------------------------------------------
  // trap and status outputs
  // ----------------------------------------------------------------
  wire logic [1:0] armed   = trap_q & {hi_ov_d, lo_ov_d};
  wire logic new_ovf       = hi_if.ovf || lo_if.ovf;
  wire logic hi_prec       = hi_if.ovf && trap_q[1] &&
                             (hi_sel_q == perf_pkg::grp_instr ||
                              hi_sel_q == perf_pkg::grp_miss);
  wire logic lo_prec       = lo_if.ovf && trap_q[0] &&
                             (lo_sel_q == perf_pkg::grp_instr ||
                              lo_sel_q == perf_pkg::grp_miss);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data             <= 64'h0;
      counter_out         <= 64'h0;
      priv_opcode_trap    <= 1'b0;
      counter_access_trap <= 1'b0;
      overflow_trap_req   <= 1'b0;
      precise_trap        <= 1'b0;
      soft_interrupt_reg_ov_set      <= 1'b0;
    end else begin
      rd_data             <= do_rd ? ctl_img : 64'h0;
      counter_out         <= {hi_cnt_q, lo_cnt_q};
      priv_opcode_trap    <= bad_acc;
      counter_access_trap <= cnt_deny;
      overflow_trap_req   <= |armed;
      precise_trap        <= hi_prec || lo_prec;
      soft_interrupt_reg_ov_set      <= new_ovf;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/perf_half_if.sv ----
// signals joining the top to one counter half
`timescale 1ns/1ps
`default_nettype none
interface perf_half_if;
  logic [3:0]  sel;
  logic [7:0]  mask;
  logic        count_en;
  logic        core_idle;
  logic [7:0]  instr_class;
  logic [7:0]  group_events;
  logic [31:0] value;
  logic        inc;
  logic        ovf;
  modport half (input sel, mask, count_en, core_idle, instr_class,
                group_events, value, output inc, ovf);
  modport top  (output sel, mask, count_en, core_idle, instr_class,
                group_events, value, input inc, ovf);
endinterface
`default_nettype wire

// ---- rtl/perf_half_sel.sv ----
// event selection and overflow detect for one counter half
`timescale 1ns/1ps
`default_nettype none
module perf_half_sel (
  perf_half_if.half h
);
  wire logic [7:0] class_hit = h.instr_class & h.mask;
  wire logic [7:0] grp_hit   = h.group_events & h.mask;
  wire logic       is_idle   = (h.sel == perf_pkg::grp_idle);
  wire logic       is_instr  = (h.sel == perf_pkg::grp_instr);
  wire logic       raw;
  // one increment per instruction however many classes match
  assign raw = is_idle  ? h.core_idle :
               is_instr ? (|class_hit) :
               (h.sel != 4'h1) && (|grp_hit);
  assign h.inc = raw && h.count_en;
  assign h.ovf = h.inc && (h.value >= perf_pkg::near_ovf);
endmodule
`default_nettype wire

// ---- rtl/perf_pkg.sv ----
// constants for the per-strand performance control block
package perf_pkg;
  // ----------------------------------------------------------------
  // register address and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] perf_ctl_addr  = 8'h10;
  localparam logic [63:0] perf_ctl_reset = 64'h0;
  localparam int keep_hi_bit   = 63;
  localparam int keep_lo_bit   = 62;
  localparam int hi_ov_bit     = 31;
  localparam int hi_sel_msb    = 30;
  localparam int hi_sel_lsb    = 27;
  localparam int hi_mask_msb   = 26;
  localparam int hi_mask_lsb   = 19;
  localparam int lo_ov_bit     = 18;
  localparam int lo_sel_msb    = 17;
  localparam int lo_sel_lsb    = 14;
  localparam int lo_mask_msb   = 13;
  localparam int lo_mask_lsb   = 6;
  localparam int trap_msb      = 5;
  localparam int trap_lsb      = 4;
  localparam int hyp_bit       = 3;
  localparam int user_bit      = 2;
  localparam int sup_bit       = 1;
  localparam int restrict_bit  = 0;
  localparam int soft_interrupt_reg_ov_bit = 15;
  // ----------------------------------------------------------------
  // event groups and privilege levels
  // ----------------------------------------------------------------
  localparam logic [3:0] grp_idle  = 4'h0;
  localparam logic [3:0] grp_instr = 4'h2;
  localparam logic [3:0] grp_miss  = 4'h3;
  localparam logic [31:0] near_ovf = 32'hfffffff0;
  typedef enum logic [1:0] {priv_user, priv_sup, priv_hyp} priv_e;
endpackage

// ---- tb/perf_event_control_assertions.sv ----
// port-level checks for the performance control block
`timescale 1ns/1ps
`default_nettype none
module perf_event_control_assertions #(
  parameter int cnt_w = 32
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [1:0]  cur_priv,
  input wire logic        ctl_wr,
  input wire logic        ctl_rd,
  input wire logic [7:0]  asr_addr,
  input wire logic [63:0] wr_data,
  input wire logic        cnt_wr,
  input wire logic        cnt_rd,
  input wire logic [63:0] cnt_wr_data,
  input wire logic        core_idle,
  input wire logic [7:0]  instr_class,
  input wire logic        instr_valid,
  input wire logic [7:0]  group_events,
  input wire logic [63:0] rd_data,
  input wire logic [63:0] counter_out,
  input wire logic        priv_opcode_trap,
  input wire logic        counter_access_trap,
  input wire logic        overflow_trap_req,
  input wire logic        precise_trap,
  input wire logic        soft_interrupt_reg_ov_set
);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  wire user_acc = (ctl_wr || ctl_rd) && asr_addr == 8'h10 && cur_priv == 2'h0;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence user_hit;
    user_acc;
  endsequence
  sequence quiet;
    !cnt_wr && !core_idle && !instr_valid && group_events == 8'h0;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_user_trap: assert property (user_hit |=> priv_opcode_trap)
    else $error("user access not trapped");
  chk_no_false_trap: assert property (!user_acc |=> !priv_opcode_trap)
    else $error("trap without user access");
  chk_user_rd_zero: assert property (user_hit ##0 ctl_rd |=> rd_data == 64'h0)
    else $error("user read returned data");
  chk_keep_read_zero: assert property (rd_data[63:62] == 2'b00)
    else $error("keep bits read nonzero");
  chk_reserved_zero: assert property (rd_data[61:32] == 30'h0)
    else $error("reserved bits read nonzero");
  chk_counter_hold: assert property (quiet [*3] |=> $stable(counter_out))
    else $error("counter moved without events");
  chk_priv_cnt_ok: assert property ((cnt_rd || cnt_wr) && cur_priv != 2'h0
    |=> !counter_access_trap) else $error("privileged counter access denied");
  chk_trap_req_fall: assert property ($fell(overflow_trap_req)
    |-> $past(ctl_wr) || $past(ctl_wr, 2)) else $error("trap request fell alone");
endmodule
bind perf_event_control perf_event_control_assertions #(.cnt_w(cnt_w)) chk (
  .sys_clk(sys_clk), .rst(rst), .cur_priv(cur_priv), .ctl_wr(ctl_wr),
  .ctl_rd(ctl_rd), .asr_addr(asr_addr), .wr_data(wr_data), .cnt_wr(cnt_wr),
  .cnt_rd(cnt_rd), .cnt_wr_data(cnt_wr_data), .core_idle(core_idle),
  .instr_class(instr_class), .instr_valid(instr_valid),
  .group_events(group_events), .rd_data(rd_data), .counter_out(counter_out),
  .priv_opcode_trap(priv_opcode_trap), .counter_access_trap(counter_access_trap),
  .overflow_trap_req(overflow_trap_req), .precise_trap(precise_trap),
  .soft_interrupt_reg_ov_set(soft_interrupt_reg_ov_set));
`default_nettype wire

// ---- tb/perf_event_control_tb.sv ----
// self-checking bench for the performance control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_count++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module perf_event_control_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  cur_priv = 2'h0;
  logic        ctl_wr = 1'b0, ctl_rd = 1'b0, cnt_wr = 1'b0, cnt_rd = 1'b0;
  logic [7:0]  asr_addr = 8'h10, instr_class = 8'h0;
  logic [7:0]  group_events = 8'h00;
  logic [63:0] wr_data = 64'h0, cnt_wr_data = 64'h0, rd_data, counter_out, d;
  logic        core_idle = 1'b0, instr_valid = 1'b0;
  logic        priv_opcode_trap, counter_access_trap, overflow_trap_req;
  logic        precise_trap, soft_interrupt_reg_ov_set;
  int          err_count = 0, check_count = 0, cyc = 0, n_op = 0, n_deny = 0;
  int          n_sw = 0, n_pre = 0, b;
  perf_event_control #(.cnt_w(32)) DUT (.sys_clk(sys_clk), .rst(rst),
    .cur_priv(cur_priv), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .asr_addr(asr_addr),
    .wr_data(wr_data), .cnt_wr(cnt_wr), .cnt_rd(cnt_rd),
    .cnt_wr_data(cnt_wr_data), .core_idle(core_idle), .instr_class(instr_class),
    .instr_valid(instr_valid), .group_events(group_events), .rd_data(rd_data),
    .counter_out(counter_out), .priv_opcode_trap(priv_opcode_trap),
    .counter_access_trap(counter_access_trap),
    .overflow_trap_req(overflow_trap_req), .precise_trap(precise_trap),
    .soft_interrupt_reg_ov_set(soft_interrupt_reg_ov_set));
  // ------------------------------------------------------------
  // clock, pulse tallies and hang limit
  // ------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    n_op += (priv_opcode_trap === 1'b1);
    n_deny += (counter_access_trap === 1'b1);
    n_sw += (soft_interrupt_reg_ov_set === 1'b1);
    n_pre += (precise_trap === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic acc(input logic [1:0] p, input logic [2:0] k, input logic [63:0] v);
    @(negedge sys_clk);
    cur_priv = p;
    {ctl_wr, ctl_rd, cnt_wr} = k;
    wr_data = v;
    cnt_wr_data = v;
    @(negedge sys_clk);
    {ctl_wr, ctl_rd, cnt_wr} = 3'b000;
    d = rd_data;
  endtask
  task automatic ev(input logic [7:0] c, input logic idl);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_class = c;
    core_idle = idl;
  endtask
  task automatic burst();
    ev(8'h08, 1'b1);
    ev(8'h08, 1'b1);
    ev(8'h10, 1'b0);
    ev(8'h18, 1'b0);
    ev(8'h80, 1'b0);
    ev(8'h01, 1'b0);
    @(negedge sys_clk);
    {instr_valid, core_idle} = 2'b00;
    repeat (3) @(negedge sys_clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_fields();
    acc(2'h2, 3'b010, 64'h0);
    `CHK("reset image", 64'h0, d)
    acc(2'h2, 3'b100, 64'hffff_ffff_ffff_ffc7);
    acc(2'h2, 3'b010, 64'h0);
    `CHK("keep both", 64'h7ffb_ffc7, d)
    acc(2'h2, 3'b100, 64'h0000_0000_8004_0030);
    acc(2'h2, 3'b010, 64'h0);
    `CHK("flags load", 64'h8004_0030, d)
    `CHK("trap both", 1'b1, overflow_trap_req)
    acc(2'h2, 3'b100, 64'hc000_0000_0000_0010);
    acc(2'h2, 3'b010, 64'h0);
    `CHK("flags held", 64'h8004_0010, d)
    acc(2'h2, 3'b100, 64'h8000_0000_0000_0010);
    `CHK("trap low off", 1'b0, overflow_trap_req)
    acc(2'h2, 3'b010, 64'h0);
    `CHK("low only", 64'h8000_0010, d)
    acc(2'h2, 3'b100, 64'h8);
    acc(2'h1, 3'b100, 64'h0);
    acc(2'h1, 3'b010, 64'h0);
    `CHK("hyp bit sup", 64'h8, d)
    b = n_op;
    acc(2'h0, 3'b100, 64'h6);
    @(negedge sys_clk);
    `CHK("user trap", 1, n_op - b)
    acc(2'h2, 3'b010, 64'h0);
    `CHK("user no change", 64'h8, d)
    acc(2'h2, 3'b100, 64'h0);
    acc(2'h2, 3'b010, 64'h0);
    `CHK("hyp bit hyp", 64'h0, d)
    $display("fields test done");
  endtask
  task automatic t_count();
    acc(2'h2, 3'b100, 64'h8602);
    acc(2'h1, 3'b001, 64'h0);
    burst();
    `CHK("sup count", {32'd2, 32'd5}, counter_out)
    acc(2'h1, 3'b100, 64'h8600);
    burst();
    `CHK("sup off", {32'd2, 32'd5}, counter_out)
    acc(2'h1, 3'b100, 64'h8604);
    cur_priv = 2'h0;
    burst();
    `CHK("user count", {32'd4, 32'd10}, counter_out)
    acc(2'h1, 3'b100, 64'h1808_0002);
    @(negedge sys_clk);
    group_events = 8'h03;
    repeat (2) @(negedge sys_clk);
    group_events = 8'h00;
    repeat (3) @(negedge sys_clk);
    `CHK("group 3 count", {32'd6, 32'd10}, counter_out)
    $display("count test done");
  endtask
  task automatic t_ovf();
    acc(2'h2, 3'b100, 64'h8612);
    acc(2'h1, 3'b001, 64'h0000_0000_ffff_fffe);
    b = n_sw + n_pre;
    ev(8'h08, 1'b0);
    ev(8'h08, 1'b0);
    @(negedge sys_clk);
    instr_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("wrap", 64'h0, counter_out)
    `CHK("soft_interrupt_reg and precise", 4, n_sw + n_pre - b)
    `CHK("trap armed", 1'b1, overflow_trap_req)
    acc(2'h1, 3'b010, 64'h0);
    `CHK("low flag", 64'h4_8612, d)
    acc(2'h1, 3'b100, 64'h8613);
    b = n_deny;
    @(negedge sys_clk);
    cur_priv = 2'h0;
    cnt_rd = 1'b1;
    @(negedge sys_clk);
    cnt_rd = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("deny user", 1, n_deny - b)
    `CHK("trap cleared", 1'b0, overflow_trap_req)
    $display("overflow test done");
  endtask
  // ------------------------------------------------------------
  // closing report and main sequence
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_fields();
    t_count();
    t_ovf();
    summarize();
  end
endmodule
`default_nettype wire
